// ### bhpm_regs.sv
// bridge header tail and power-management capability registers of one port
//
// Overview of operation
// RULE1: upper prefetch limit writable only for 64-bit
// RULE2: io base upper in 15:0, resets ffffh
// RULE3: io limit upper in 31:16, resets zero
// RULE4: read-only capability pointer defaults to 40h
// RULE5: interrupt line byte, read-write, no effect
// RULE6: interrupt pin read-only, 00h or 01h
// RULE7: bit 16 enables secondary parity error status
// RULE8: bit 17 with command enable permits error forwarding
// RULE9: isa bit blocks downstream io alias addresses
// RULE10: vga bit forwards a0000h-bffffh downstream only
// RULE11: vga io ranges 3b0h-3bbh, 3c0h-3dfh forwarded
// RULE12: vga forwarding ignores windows, needs access enables
// RULE13: bit 20 selects 10- or 16-bit vga decode
// RULE14: bit 22 drives hot reset on downstream link
// RULE15: unused bridge control bits read zero
// RULE16: expansion rom base reads zero, ignores writes
// RULE17: pm header id 01h, next 48h, version 3
// RULE18: wake event mask defaults 11001b, no d1/d2
// RULE19: aux current read-only, preload may set it
// RULE20: power state holds d0 or d3hot
// RULE21: unsupported power state writes are discarded
// RULE22: parity error set on poison, write one clears
// RULE23: own copy; read-only writes ignored, reserved zero
`timescale 1ns/100ps
`default_nettype none

module bhpm_regs
    import bhpm_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic rst_i, // synchronous reset, active high
    input wire bhpm_pkg::bhpm_cfg_req_t cfg_i, // configuration access
    input wire bhpm_pkg::bhpm_ctx_t ctx_i, // command and capability settings
    input wire bhpm_pkg::bhpm_route_req_t route_i, // address to route
    input wire logic poison_cpl_i, // poisoned completion received downstream
    input wire logic poison_wr_fwd_i, // poisoned write forwarded downstream
    output logic [31:0] rdata_o, // read data
    output logic rvalid_o, // read data valid pulse
    output logic hot_reset_o, // hot reset request for the downstream link
    output logic err_forward_o, // error messages may go upstream
    output logic sys_err_permit_o, // signaled system error may be set
    output logic [1:0] power_state_o, // current power state
    output logic sec_parity_err_o, // secondary master data parity error
    output logic fwd_down_o, // route answer: forward downstream
    output logic fwd_up_o, // route answer: forward upstream
    output logic route_valid_o // route answer valid pulse
);
    import bhpm_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [31:0] pf_lim_up; // upper prefetch limit
        logic [15:0] io_base_up; // io base bits 31:16
        logic [15:0] io_lim_up; // io limit bits 31:16
        logic [7:0] cap_ptr; // capability list start
        logic [7:0] int_line; // interrupt routing byte
        logic int_pin_a; // interrupt pin: 1 = line a, 0 = none
        logic parity_resp; // bridge control bit 16
        logic error_forward_en; // bridge control bit 17
        logic legacy_io_alias_block; // bridge control bit 18
        logic vga_en; // bridge control bit 19
        logic vga16; // bridge control bit 20
        logic hot_reset; // bridge control bit 22
        logic [2:0] aux_cur; // aux current field
        logic [4:0] wake_event_state_mask; // wake event support
        logic [1:0] pwr_state; // power state
        logic par_err; // secondary parity error status
        logic [31:0] rdata; // read data
        logic rvalid; // read data valid
        logic sys_err_permit; // system error permission
        logic fwd_down; // route answer downstream
        logic fwd_up; // route answer upstream
        logic route_valid; // route answer valid
    } bhpm_state_t;

    bhpm_state_t state_q; // registered state
    bhpm_state_t state_d; // next state

    // merge write data into a word under the byte enables
    function automatic logic [31:0] bhpm_merge(
        input logic [31:0] cur,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = cur;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when two byte addresses hit the same dword
    function automatic logic bhpm_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // word view of each register as software sees it
    logic [31:0] w_pf_lim_up; // 2ch
    logic [31:0] w_io_upper; // 30h
    logic [31:0] w_cap_start; // 34h
    logic [31:0] w_bridge_ctl; // 3ch
    logic [31:0] w_pm_cap; // 40h
    logic [31:0] w_pm_csr; // 44h
    logic [31:0] w_sec_status; // 1ch, only the parity bit lives here

    // assemble read words; read-only zeros where capability is absent
    always_comb
    begin
        w_pf_lim_up = ctx_i.pf_limit_64 ? state_q.pf_lim_up : '0; // [RULE1]
        w_io_upper = '0;
        w_io_upper[15:0] = ctx_i.io_base_32 ? state_q.io_base_up : '0; // [RULE2]
        w_io_upper[31:16] = ctx_i.io_limit_32 ? state_q.io_lim_up : '0; // [RULE3]
        w_cap_start = {24'h0, state_q.cap_ptr}; // [RULE4]
        w_bridge_ctl = '0; // reserved bits stay zero [RULE15]
        w_bridge_ctl[7:0] = state_q.int_line; // [RULE5]
        w_bridge_ctl[15:8] = {7'h0, state_q.int_pin_a}; // [RULE6]
        w_bridge_ctl[BHPM_BC_PARITY_RESP] = state_q.parity_resp;
        w_bridge_ctl[BHPM_BC_ERR_FWD] = state_q.error_forward_en;
        w_bridge_ctl[BHPM_BC_ISA] = state_q.legacy_io_alias_block;
        w_bridge_ctl[BHPM_BC_VGA] = state_q.vga_en;
        w_bridge_ctl[BHPM_BC_VGA16] = state_q.vga16;
        w_bridge_ctl[BHPM_BC_HOT_RESET] = state_q.hot_reset;
        w_pm_cap = '0; // clock, d1 and d2 bits read zero [RULE17] [RULE18]
        w_pm_cap[7:0] = BHPM_PM_CAP_ID; // [RULE17]
        w_pm_cap[15:8] = BHPM_PM_NEXT_PTR;
        w_pm_cap[18:16] = BHPM_PM_VERSION;
        w_pm_cap[BHPM_PM_AUX_LSB +: 3] = state_q.aux_cur; // [RULE19]
        w_pm_cap[BHPM_PM_WAKE_LSB +: 5] = state_q.wake_event_state_mask; // [RULE18]
        w_pm_csr = '0;
        w_pm_csr[1:0] = state_q.pwr_state; // [RULE20]
        w_pm_csr[BHPM_PM_NO_SOFT_RST] = 1'b1;
        w_sec_status = '0;
        w_sec_status[BHPM_SS_PARITY_ERR] = state_q.par_err; // [RULE22]
    end

    // write effects, status events, reads and routing
    always_comb
    begin
        logic wr_any; // any write, config or preload
        logic [31:0] m; // merged word
        logic [31:0] a; // routed address
        logic io_lo64k; // io address in first 64 kb
        logic isa_alias; // last 768 bytes of a 1 kb block
        logic vga_io; // vga io decode hit
        logic vga_mem; // vga memory decode hit
        logic [9:0] a10; // low io address bits
        state_d = state_q;
        wr_any = cfg_i.wr | cfg_i.preload;
        m = '0;
        a = route_i.addr;
        a10 = a[9:0];
        io_lo64k = a[31:16] == 16'h0000;
        isa_alias = io_lo64k && (a[9:8] != 2'h0);
        vga_io = 1'b0;
        vga_mem = 1'b0;

        // upper prefetch limit: written only with 64-bit support [RULE1]
        if (wr_any && bhpm_hit(cfg_i.addr, BHPM_OFF_PF_LIM_UP) && ctx_i.pf_limit_64)
        begin
            state_d.pf_lim_up = bhpm_merge(state_q.pf_lim_up, cfg_i.wdata, cfg_i.be);
        end

        // io upper halves, each gated by its own capability
        if (wr_any && bhpm_hit(cfg_i.addr, BHPM_OFF_IO_UPPER))
        begin
            m = bhpm_merge(w_io_upper, cfg_i.wdata, cfg_i.be);
            if (ctx_i.io_base_32)
            begin
                state_d.io_base_up = m[15:0]; // [RULE2]
            end
            if (ctx_i.io_limit_32)
            begin
                state_d.io_lim_up = m[31:16]; // [RULE3]
            end
        end

        // capability pointer: only the serial preload may change it [RULE4] [RULE23]
        if (cfg_i.preload && bhpm_hit(cfg_i.addr, BHPM_OFF_CAP_START) && cfg_i.be[0])
        begin
            state_d.cap_ptr = cfg_i.wdata[7:0];
        end

        // expansion rom base has no storage, writes fall away [RULE16]

        // bridge control and interrupt byte
        if (wr_any && bhpm_hit(cfg_i.addr, BHPM_OFF_BRIDGE_CTL))
        begin
            m = bhpm_merge(w_bridge_ctl, cfg_i.wdata, cfg_i.be);
            state_d.int_line = m[7:0]; // [RULE5]
            if (cfg_i.preload)
            begin
                state_d.int_pin_a = m[8]; // only 00h or 01h can be held [RULE6]
            end
            state_d.parity_resp = m[BHPM_BC_PARITY_RESP]; // [RULE7]
            state_d.error_forward_en = m[BHPM_BC_ERR_FWD]; // [RULE8]
            state_d.legacy_io_alias_block = m[BHPM_BC_ISA]; // [RULE9]
            state_d.vga_en = m[BHPM_BC_VGA]; // [RULE10]
            state_d.vga16 = m[BHPM_BC_VGA16]; // [RULE13]
            state_d.hot_reset = m[BHPM_BC_HOT_RESET]; // [RULE14]
        end

        // power_mgmt_capability: read-only to software, preload fills aux and wake fields
        if (cfg_i.preload && bhpm_hit(cfg_i.addr, BHPM_OFF_PM_CAP))
        begin
            m = bhpm_merge(w_pm_cap, cfg_i.wdata, cfg_i.be);
            state_d.aux_cur = m[BHPM_PM_AUX_LSB +: 3]; // [RULE19]
            state_d.wake_event_state_mask = m[BHPM_PM_WAKE_LSB +: 5]; // [RULE18]
        end

        // power state: only d0 and d3hot are taken [RULE20]
        if (wr_any && bhpm_hit(cfg_i.addr, BHPM_OFF_PM_CSR) && cfg_i.be[0])
        begin
            if (cfg_i.wdata[1:0] == BHPM_PS_D0 || cfg_i.wdata[1:0] == BHPM_PS_D3HOT)
            begin
                state_d.pwr_state = cfg_i.wdata[1:0];
            end
            // other codes complete but are discarded [RULE21]
        end

        // parity error: write one clears, a new event in the same cycle wins
        if (cfg_i.wr && bhpm_hit(cfg_i.addr, BHPM_OFF_SEC_STATUS) && cfg_i.be[3]
            && cfg_i.wdata[BHPM_SS_PARITY_ERR])
        begin
            state_d.par_err = 1'b0; // [RULE22]
        end
        if (state_q.parity_resp && (poison_cpl_i || poison_wr_fwd_i))
        begin
            state_d.par_err = 1'b1; // [RULE7] [RULE22]
        end

        // error forwarding needs both enables [RULE8]
        state_d.sys_err_permit = state_q.error_forward_en && ctx_i.serr_en;

        // read answer one cycle after the request; unmapped reads give zero
        state_d.rvalid = cfg_i.rd;
        state_d.rdata = '0;
        if (cfg_i.rd)
        begin
            case (cfg_i.addr[7:2])
                BHPM_OFF_SEC_STATUS[7:2]: state_d.rdata = w_sec_status;
                BHPM_OFF_PF_LIM_UP[7:2]: state_d.rdata = w_pf_lim_up;
                BHPM_OFF_IO_UPPER[7:2]: state_d.rdata = w_io_upper;
                BHPM_OFF_CAP_START[7:2]: state_d.rdata = w_cap_start;
                BHPM_OFF_BRIDGE_CTL[7:2]: state_d.rdata = w_bridge_ctl;
                BHPM_OFF_PM_CAP[7:2]: state_d.rdata = w_pm_cap;
                BHPM_OFF_PM_CSR[7:2]: state_d.rdata = w_pm_csr;
                default: state_d.rdata = '0; // rom base and unmapped [RULE16] [RULE23]
            endcase
        end

        // legacy display decodes, independent of the windows [RULE12]
        if (state_q.vga_en || ctx_i.palette_snoop)
        begin
            vga_io = io_lo64k
                && ((a10 >= BHPM_VGA_IO_A_LO && a10 <= BHPM_VGA_IO_A_HI)
                || (a10 >= BHPM_VGA_IO_B_LO && a10 <= BHPM_VGA_IO_B_HI)) // [RULE11]
                && (!state_q.vga16 || a[15:10] == 6'h00); // [RULE13]
        end
        vga_io = vga_io && state_q.vga_en;
        vga_mem = state_q.vga_en && a >= BHPM_VGA_MEM_LO && a <= BHPM_VGA_MEM_HI; // [RULE10]

        // route answer
        state_d.route_valid = route_i.valid;
        state_d.fwd_down = 1'b0;
        state_d.fwd_up = 1'b0;
        if (route_i.valid && route_i.is_io)
        begin
            // isa aliases stay upstream even inside the window [RULE9]
            state_d.fwd_down = ctx_i.io_en && (vga_io || (route_i.in_window
                && !(state_q.legacy_io_alias_block && isa_alias))); // [RULE12]
            state_d.fwd_up = !vga_io && (!route_i.in_window
                || (state_q.legacy_io_alias_block && isa_alias)); // [RULE9]
        end
        else if (route_i.valid)
        begin
            state_d.fwd_down = ctx_i.mem_en && (vga_mem || route_i.in_window); // [RULE12]
            state_d.fwd_up = !vga_mem && !route_i.in_window; // [RULE10]
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_q <= '0;
            state_q.pf_lim_up <= BHPM_RST_PF_LIM_UP;
            state_q.io_base_up <= BHPM_RST_IO_BASE_UP; // [RULE2]
            state_q.io_lim_up <= BHPM_RST_IO_LIM_UP; // [RULE3]
            state_q.cap_ptr <= BHPM_RST_CAP_PTR; // [RULE4]
            state_q.int_line <= BHPM_RST_INT_LINE; // [RULE5]
            state_q.int_pin_a <= BHPM_RST_INT_PIN[0]; // [RULE6]
            state_q.aux_cur <= BHPM_RST_AUX_CUR; // [RULE19]
            state_q.wake_event_state_mask <= BHPM_RST_WAKE_MASK; // [RULE18]
            state_q.pwr_state <= BHPM_PS_D0; // [RULE20]
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state register
    assign rdata_o = state_q.rdata;
    assign rvalid_o = state_q.rvalid;
    assign hot_reset_o = state_q.hot_reset; // [RULE14]
    assign err_forward_o = state_q.error_forward_en; // [RULE8]
    assign sys_err_permit_o = state_q.sys_err_permit;
    assign power_state_o = state_q.pwr_state;
    assign sec_parity_err_o = state_q.par_err;
    assign fwd_down_o = state_q.fwd_down;
    assign fwd_up_o = state_q.fwd_up;
    assign route_valid_o = state_q.route_valid;

endmodule // bhpm_regs

`default_nettype wire

// ### bhpm_pkg.sv
// package: offsets, field positions, reset values and carriers of the bridge header tail
package bhpm_pkg;

    // register byte offsets
    localparam logic [7:0] BHPM_OFF_SEC_STATUS = 8'h1c;
    localparam logic [7:0] BHPM_OFF_PF_LIM_UP = 8'h2c;
    localparam logic [7:0] BHPM_OFF_IO_UPPER = 8'h30;
    localparam logic [7:0] BHPM_OFF_CAP_START = 8'h34;
    localparam logic [7:0] BHPM_OFF_ROM_BASE = 8'h38;
    localparam logic [7:0] BHPM_OFF_BRIDGE_CTL = 8'h3c;
    localparam logic [7:0] BHPM_OFF_PM_CAP = 8'h40;
    localparam logic [7:0] BHPM_OFF_PM_CSR = 8'h44;

    // bridge control bit positions in the 3ch word
    localparam int BHPM_BC_PARITY_RESP = 16;
    localparam int BHPM_BC_ERR_FWD = 17;
    localparam int BHPM_BC_ISA = 18;
    localparam int BHPM_BC_VGA = 19;
    localparam int BHPM_BC_VGA16 = 20;
    localparam int BHPM_BC_HOT_RESET = 22;
    // secondary master data parity error bit in the 1ch word
    localparam int BHPM_SS_PARITY_ERR = 24;
    // power-management field positions
    localparam int BHPM_PM_AUX_LSB = 22;
    localparam int BHPM_PM_WAKE_LSB = 27;
    localparam int BHPM_PM_NO_SOFT_RST = 3;

    // reset values
    localparam logic [31:0] BHPM_RST_PF_LIM_UP = 32'h0000_0000;
    localparam logic [15:0] BHPM_RST_IO_BASE_UP = 16'hffff;
    localparam logic [15:0] BHPM_RST_IO_LIM_UP = 16'h0000;
    localparam logic [7:0] BHPM_RST_CAP_PTR = 8'h40;
    localparam logic [7:0] BHPM_RST_INT_LINE = 8'h00;
    localparam logic [7:0] BHPM_RST_INT_PIN = 8'h01;
    localparam logic [7:0] BHPM_PM_CAP_ID = 8'h01;
    localparam logic [7:0] BHPM_PM_NEXT_PTR = 8'h48;
    localparam logic [2:0] BHPM_PM_VERSION = 3'h3;
    localparam logic [2:0] BHPM_RST_AUX_CUR = 3'h0;
    localparam logic [4:0] BHPM_RST_WAKE_MASK = 5'h19;
    localparam logic [1:0] BHPM_PS_D0 = 2'h0;
    localparam logic [1:0] BHPM_PS_D3HOT = 2'h3;

    // legacy address windows
    localparam logic [31:0] BHPM_VGA_MEM_LO = 32'h000a_0000;
    localparam logic [31:0] BHPM_VGA_MEM_HI = 32'h000b_ffff;
    localparam logic [9:0] BHPM_VGA_IO_A_LO = 10'h3b0;
    localparam logic [9:0] BHPM_VGA_IO_A_HI = 10'h3bb;
    localparam logic [9:0] BHPM_VGA_IO_B_LO = 10'h3c0;
    localparam logic [9:0] BHPM_VGA_IO_B_HI = 10'h3df;

    // configuration access carrier: read, write or serial preload
    typedef struct packed {
        logic rd;
        logic wr;
        logic preload;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bhpm_cfg_req_t;

    // address to be routed, with the window hit from the base/limit logic
    typedef struct packed {
        logic valid;
        logic is_io;
        logic in_window;
        logic [31:0] addr;
    } bhpm_route_req_t;

    // settings taken from the primary command and other header registers
    typedef struct packed {
        logic io_en;
        logic mem_en;
        logic serr_en;
        logic palette_snoop;
        logic pf_limit_64;
        logic io_base_32;
        logic io_limit_32;
    } bhpm_ctx_t;

endpackage : bhpm_pkg

// ### bhpm_regs_properties.sv
// checker: timing relations at the ports of the bridge header tail registers
`timescale 1ns/100ps
`default_nettype none

module bhpm_regs_properties
    import bhpm_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic rst_i, // sync reset
    input wire bhpm_pkg::bhpm_cfg_req_t cfg_i, // config access
    input wire bhpm_pkg::bhpm_ctx_t ctx_i, // command settings
    input wire bhpm_pkg::bhpm_route_req_t route_i, // route request
    input wire logic poison_cpl_i, // poisoned completion
    input wire logic poison_wr_fwd_i, // poisoned write forwarded
    input wire logic [31:0] rdata_o, // read data
    input wire logic rvalid_o, // read answer
    input wire logic hot_reset_o, // hot reset level
    input wire logic err_forward_o, // error forwarding level
    input wire logic sys_err_permit_o, // system error permit
    input wire logic [1:0] power_state_o, // power state
    input wire logic sec_parity_err_o, // parity error status
    input wire logic fwd_down_o, // forward downstream
    input wire logic fwd_up_o, // forward upstream
    input wire logic route_valid_o // route answer
);
    logic wr_any; // write or preload
    logic w3c; // bridge control byte 2 written
    logic w44; // power state byte written
    logic w1c; // parity status cleared
    logic [7:0] bc2_q; // shadow of bridge control 23:16
    logic [7:0] bc2_d; // next shadow
    assign wr_any = cfg_i.wr | cfg_i.preload;
    assign w3c = wr_any & cfg_i.be[2] & (cfg_i.addr[7:2] == BHPM_OFF_BRIDGE_CTL[7:2]);
    assign w44 = wr_any & cfg_i.be[0] & (cfg_i.addr[7:2] == BHPM_OFF_PM_CSR[7:2]);
    assign w1c = wr_any & cfg_i.be[3] & cfg_i.wdata[24]
        & (cfg_i.addr[7:2] == BHPM_OFF_SEC_STATUS[7:2]);
    // shadow follows every bridge control write
    always_comb
    begin
        bc2_d = w3c ? cfg_i.wdata[23:16] : bc2_q;
    end
    always_ff @(posedge clock_i)
    begin
        bc2_q <= rst_i ? 8'h00 : bc2_d;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_read; cfg_i.rd |=> rvalid_o; endproperty
    a_read: assert property (p_read) else $error("read not answered");
    property p_rom; cfg_i.rd && cfg_i.addr[7:2] == BHPM_OFF_ROM_BASE[7:2] |=> rdata_o == 32'h0; endproperty
    a_rom: assert property (p_rom) else $error("rom base not zero");
    property p_hot; w3c |=> hot_reset_o == $past(cfg_i.wdata[22]); endproperty
    a_hot: assert property (p_hot) else $error("hot reset wrong");
    property p_efwd; w3c |=> err_forward_o == $past(cfg_i.wdata[17]); endproperty
    a_efwd: assert property (p_efwd) else $error("error forward wrong");
    property p_serr; (err_forward_o && ctx_i.serr_en)[*2] |=> sys_err_permit_o; endproperty
    a_serr: assert property (p_serr) else $error("system error not permitted");
    property p_ps_keep; w44 && cfg_i.wdata[1:0] inside {2'h1, 2'h2} |=> $stable(power_state_o); endproperty
    a_ps_keep: assert property (p_ps_keep) else $error("bad state taken");
    property p_ps_take; w44 && cfg_i.wdata[1:0] inside {2'h0, 2'h3}
        |=> power_state_o == $past(cfg_i.wdata[1:0]); endproperty
    a_ps_take: assert property (p_ps_take) else $error("state not taken");
    property p_par_set; (poison_cpl_i || poison_wr_fwd_i) && bc2_q[0] |=> sec_parity_err_o; endproperty
    a_par_set: assert property (p_par_set) else $error("parity not set");
    property p_par_off; !bc2_q[0] && !sec_parity_err_o |=> !sec_parity_err_o; endproperty
    a_par_off: assert property (p_par_off) else $error("parity set disabled");
    property p_par_hold; sec_parity_err_o && !w1c |=> sec_parity_err_o; endproperty
    a_par_hold: assert property (p_par_hold) else $error("parity lost");
    property p_vga; route_i.valid && !route_i.is_io && bc2_q[3] && ctx_i.mem_en
        && route_i.addr inside {[BHPM_VGA_MEM_LO:BHPM_VGA_MEM_HI]} |=> fwd_down_o && !fwd_up_o;
    endproperty
    a_vga: assert property (p_vga) else $error("vga memory misrouted");
endmodule // bhpm_regs_properties

bind bhpm_regs bhpm_regs_properties bhpm_regs_properties_inst (.clock_i(clock_i),
    .rst_i(rst_i), .cfg_i(cfg_i), .ctx_i(ctx_i), .route_i(route_i),
    .poison_cpl_i(poison_cpl_i), .poison_wr_fwd_i(poison_wr_fwd_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .hot_reset_o(hot_reset_o), .err_forward_o(err_forward_o),
    .sys_err_permit_o(sys_err_permit_o), .power_state_o(power_state_o),
    .sec_parity_err_o(sec_parity_err_o), .fwd_down_o(fwd_down_o), .fwd_up_o(fwd_up_o),
    .route_valid_o(route_valid_o));
`default_nettype wire

// ### bhpm_host.sv
// host model: configuration software issuing register requests
`timescale 1ns/100ps
`default_nettype none

module bhpm_host
    import bhpm_pkg::*;
(
    input wire logic clock_i, // core clock
    output var bhpm_pkg::bhpm_cfg_req_t cfg_o, // request to the block
    input wire logic [31:0] rdata_i, // read data
    input wire logic rvalid_i // read answer
);
    logic [31:0] got; // last read answer
    initial cfg_o = '0;
    // one request cycle; released strobes drop to zero, other lines show the inverse, never stale values
    task automatic put(input logic [2:0] k, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
    begin
        @(negedge clock_i);
        cfg_o = {k, a, be, d};
        @(negedge clock_i);
        cfg_o = {3'b000, ~a, ~be, ~d};
    end
    endtask
    // read: answer is sampled half a cycle after the taking edge
    task automatic get(input logic [7:0] a);
    begin
        put(3'b100, a, 4'hf, 32'h0);
        got = rvalid_i ? rdata_i : 32'hdead_beef;
    end
    endtask
endmodule // bhpm_host
`default_nettype wire

// ### bhpm_regs_tb.sv
// testbench: register access, routing and status checks of the header tail
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end

module bhpm_regs_tb;
    import bhpm_pkg::*;
    logic clock_i = 1'b0; // core clock
    logic rst_i = 1'b1; // reset
    bhpm_cfg_req_t cfg; // request from host model
    bhpm_ctx_t ctx = '0; // command settings
    bhpm_route_req_t rt = '0; // route request
    logic p_cpl = 1'b0; // poisoned completion
    logic p_fwd = 1'b0; // poisoned write forwarded
    logic [31:0] rdata; // read data
    logic rvalid, hot, efwd, serr, perr, dn, up, rv; // block outputs
    logic [1:0] ps; // power state
    int n_checks = 0; // comparisons made
    int n_errors = 0; // mismatches
    logic [7:0] offs [7] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
    logic [31:0] rst_v [7] = '{32'h0, 32'h0000_ffff, 32'h40, 32'h0, 32'h0000_0100,
        32'hc803_4801, 32'h8};
    logic [31:0] one_v [7] = '{32'hffff_ffff, 32'hffff_ffff, 32'h40, 32'h0, 32'h005f_01ff,
        32'hc803_4801, 32'hb};
    logic [1:0] psc [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h1}; // codes written
    logic [1:0] pse [5] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h3}; // state expected

    bhpm_regs bhpm_regs_inst (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg), .ctx_i(ctx),
        .route_i(rt), .poison_cpl_i(p_cpl), .poison_wr_fwd_i(p_fwd), .rdata_o(rdata),
        .rvalid_o(rvalid), .hot_reset_o(hot), .err_forward_o(efwd), .sys_err_permit_o(serr),
        .power_state_o(ps), .sec_parity_err_o(perr), .fwd_down_o(dn), .fwd_up_o(up),
        .route_valid_o(rv));
    bhpm_host bhpm_host_inst (.clock_i(clock_i), .cfg_o(cfg), .rdata_i(rdata),
        .rvalid_i(rvalid));

    always #25 clock_i = ~clock_i;

    // register write through the host model
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        bhpm_host_inst.put(3'b010, a, be, d);
    endtask
    // register read compared with an expected word
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
    begin
        bhpm_host_inst.get(a);
        `CHK(bhpm_host_inst.got, e)
    end
    endtask
    // set bridge control byte 2, then route one address
    task automatic ro(input logic [7:0] bc, input logic io, win, input logic [31:0] a,
        input logic de, ue);
    begin
        wr(BHPM_OFF_BRIDGE_CTL, 4'h4, {8'h00, bc, 16'h0000});
        rt = {1'b1, io, win, a};
        @(negedge clock_i);
        `CHK({rv, dn, up}, {1'b1, de, ue})
        rt = {1'b0, ~io, ~win, ~a};
    end
    endtask
    // counts and verdict
    task automatic tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // watchdog far beyond the roughly 150 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clock_i);
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        ctx = '1;
        for (int i = 0; i < 7; i++) rc(offs[i], rst_v[i]);
        $display("test reset values done");
        for (int i = 0; i < 7; i++) wr(offs[i], (i == 6) ? 4'h1 : 4'hf, 32'hffff_ffff);
        for (int i = 0; i < 7; i++) rc(offs[i], one_v[i]);
        `CHK({hot, efwd, serr}, 3'b111)
        ctx.serr_en = 1'b0;
        repeat (3) @(negedge clock_i);
        `CHK(serr, 1'b0)
        ctx = 7'h78;
        rc(BHPM_OFF_PF_LIM_UP, 32'h0);
        rc(BHPM_OFF_IO_UPPER, 32'h0);
        wr(BHPM_OFF_PF_LIM_UP, 4'hf, 32'h1234_5678);
        rc(BHPM_OFF_PF_LIM_UP, 32'h0);
        ctx = '1;
        $display("test access kinds done");
        foreach (psc[i])
        begin
            wr(BHPM_OFF_PM_CSR, 4'h1, {30'h0, psc[i]});
            rc(BHPM_OFF_PM_CSR, {28'h0, 2'b10, pse[i]});
            `CHK(ps, pse[i])
        end
        bhpm_host_inst.put(3'b001, BHPM_OFF_PM_CAP, 4'hf, 32'hc9c3_4801);
        rc(BHPM_OFF_PM_CAP, 32'hc9c3_4801);
        wr(BHPM_OFF_PM_CAP, 4'hf, 32'h0);
        rc(BHPM_OFF_PM_CAP, 32'hc9c3_4801);
        $display("test power management done");
        wr(BHPM_OFF_BRIDGE_CTL, 4'h4, 32'h0);
        `CHK(hot, 1'b0)
        @(negedge clock_i) p_cpl = 1'b1;
        @(negedge clock_i) p_cpl = 1'b0;
        `CHK(perr, 1'b0)
        wr(BHPM_OFF_BRIDGE_CTL, 4'h4, 32'h0001_0000);
        @(negedge clock_i) p_fwd = 1'b1;
        @(negedge clock_i) p_fwd = 1'b0;
        `CHK(perr, 1'b1)
        rc(BHPM_OFF_SEC_STATUS, 32'h0100_0000);
        wr(BHPM_OFF_SEC_STATUS, 4'h8, 32'h0100_0000);
        `CHK(perr, 1'b0)
        $display("test parity status done");
        ro(8'h08, 1'b0, 1'b0, 32'h000a_0000, 1'b1, 1'b0);
        ro(8'h08, 1'b0, 1'b0, 32'h000b_ffff, 1'b1, 1'b0);
        ro(8'h08, 1'b0, 1'b0, 32'h000c_0000, 1'b0, 1'b1);
        ro(8'h00, 1'b0, 1'b0, 32'h000a_0000, 1'b0, 1'b1);
        ro(8'h08, 1'b1, 1'b0, 32'h0000_03c0, 1'b1, 1'b0);
        ro(8'h08, 1'b1, 1'b0, 32'h0000_07df, 1'b1, 1'b0);
        ro(8'h08, 1'b1, 1'b0, 32'h0000_03bc, 1'b0, 1'b1);
        ro(8'h08, 1'b1, 1'b0, 32'h0001_03b0, 1'b0, 1'b1);
        ro(8'h18, 1'b1, 1'b0, 32'h0000_07b0, 1'b0, 1'b1);
        ro(8'h18, 1'b1, 1'b0, 32'h0000_03bb, 1'b1, 1'b0);
        ro(8'h04, 1'b1, 1'b1, 32'h0000_0100, 1'b0, 1'b1);
        ro(8'h04, 1'b1, 1'b1, 32'h0000_0400, 1'b1, 1'b0);
        ro(8'h04, 1'b1, 1'b1, 32'h0001_0100, 1'b1, 1'b0);
        ro(8'h00, 1'b1, 1'b1, 32'h0000_0100, 1'b1, 1'b0);
        ctx.mem_en = 1'b0;
        ro(8'h08, 1'b0, 1'b0, 32'h000a_0000, 1'b0, 1'b0);
        ro(8'h00, 1'b0, 1'b1, 32'h0010_0000, 1'b0, 1'b0);
        $display("test routing done");
        tally_and_finish();
    end
endmodule // bhpm_regs_tb
`default_nettype wire
